/* File: asc_pkg.sv */
/*
  package for the converter status and first control register block:
  offsets, field positions, reset values and sequencer states.
  assumes a 32-bit APB register bus and one 125 MHz clock.
*/
`default_nettype none
package asc_pkg;
  // register byte offsets
  localparam logic [11:0] STATUS_OFS  = 12'h000;
  localparam logic [11:0] CTRL1_OFS   = 12'h004;
  localparam logic [11:0] WHIGH_OFS   = 12'h024;
  localparam logic [11:0] WLOW_OFS    = 12'h028;
  localparam logic [11:0] RESULT_OFS  = 12'h04c;
  // status bit positions
  localparam int ST_WATCH   = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_JDONE   = 2;
  localparam int ST_JSTART  = 3;
  localparam int ST_RSTART  = 4;
  // control bit positions
  localparam int C_WCH_LO   = 0;
  localparam int C_DONE_IE  = 5;
  localparam int C_WATCH_IE = 6;
  localparam int C_JDONE_IE = 7;
  localparam int C_SCAN     = 8;
  localparam int C_WSINGLE  = 9;
  localparam int C_AUTOJ    = 10;
  localparam int C_RBURST   = 11;
  localparam int C_JBURST   = 12;
  localparam int C_BCNT_LO  = 13;
  localparam int C_WINJ     = 22;
  localparam int C_WREG     = 23;
  localparam int C_TOUCH_KEY_UNIT     = 24;
  // writable masks and reset values
  localparam logic [31:0] STATUS_MASK  = 32'h0000001f;
  localparam logic [31:0] CTRL1_MASK   = 32'h01c0ffef;
  localparam logic [31:0] STATUS_RST   = 32'h00000000;
  localparam logic [31:0] CTRL1_RST    = 32'h00000000;
  localparam logic [11:0] WHIGH_RST    = 12'hfff;
  localparam logic [11:0] WLOW_RST     = 12'h000;
  // conversion time of one channel
  localparam int CONV_NS     = 112;
  localparam int CLK_NS      = 8;
  localparam int CONV_CYCLES = (CONV_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_REG, SEQ_INJ} asc_seq_t;
endpackage
`default_nettype wire

/* File: asc_ctrl.sv */
/*
  converter status flags, control register one, watchdog thresholds and a
  small channel sequencer standing in for the converter's sequencing.
  assumes an APB master on ref_clk; conversion results arrive on sampleIn
  when the sequencer asks for them and are taken as ready at the end of
  each conversion slot.
*/
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module asc_ctrl
  import asc_pkg::*;
#(
  parameter int REG_LEN = 16,             // regular sequence length
  parameter int INJ_LEN = 4               // injected sequence length
) (
  input  wire logic        ref_clk,       // system clock
  input  wire logic        rst,           // synchronous reset, active high
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error on unmapped address
  input  wire logic        regularTrig,   // regular group trigger pulse
  input  wire logic        injectedTrig,  // injected group trigger pulse
  input  wire logic [11:0] sampleIn,      // result of the channel converting
  output logic      [3:0]  channelOut,    // channel being converted
  output logic             convActive,    // a conversion slot is running
  output logic             touchKeyOn,    // touch key unit enable
  output logic             irqOut         // converter interrupt request
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [4:0]  statusQ;
  logic [31:0] ctrlQ;
  logic [11:0] highQ, lowQ, resultQ;
  asc_seq_t    seqQ;
  logic [3:0]  idxQ;           // position within the running group
  logic [3:0]  rBaseQ, jBaseQ; // next subgroup start in burst mode
  logic [2:0]  burstQ;         // channels done in this burst
  logic [7:0]  slotQ;          // cycles left of the current conversion
  logic        autoPendQ;

  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire wrAcc  = access & pwrite;
  wire rdAcc  = access & ~pwrite;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == STATUS_OFS) || (a == CTRL1_OFS) || (a == WHIGH_OFS) ||
             (a == WLOW_OFS) || (a == RESULT_OFS);
  endfunction

  // ---------------------------------------------------------------
  // apb slave: no wait state, answer in the first cycle of the access phase
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped(paddr);
      prdata  <= 32'h00000000;
      if (setup && !pwrite) begin
        case (paddr)
          STATUS_OFS: prdata <= {27'h0000000, statusQ};
          CTRL1_OFS:  prdata <= ctrlQ & CTRL1_MASK;
          WHIGH_OFS:  prdata <= {20'h00000, highQ};
          WLOW_OFS:   prdata <= {20'h00000, lowQ};
          RESULT_OFS: prdata <= {20'h00000, resultQ};
          default:    prdata <= 32'h00000000;
        endcase
      end
    end
  end
  // the access edge is the one where pready is high
  wire wrNow = wrAcc & pready;
  wire rdNow = rdAcc & pready;

  // ---------------------------------------------------------------
  // control and limit registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrlQ <= CTRL1_RST;
      highQ <= WHIGH_RST;
      lowQ  <= WLOW_RST;
    end else if (wrNow) begin
      if (paddr == CTRL1_OFS) ctrlQ <= pwdata & CTRL1_MASK;
      if (paddr == WHIGH_OFS) highQ <= pwdata[11:0];
      if (paddr == WLOW_OFS)  lowQ  <= pwdata[11:0];
    end
  end

  wire       scanOn   = ctrlQ[C_SCAN];
  wire       rBurst   = ctrlQ[C_RBURST];
  wire       jBurst   = ctrlQ[C_JBURST];
  wire [2:0] bcnt     = ctrlQ[C_BCNT_LO +: 3];
  wire [3:0] watchCh  = ctrlQ[C_WCH_LO +: 4];

  // ---------------------------------------------------------------
  // sequencer: slot counting and channel stepping
  // ---------------------------------------------------------------
  wire slotEnd   = (seqQ != SEQ_IDLE) && (slotQ == 8'h00);
  wire [3:0] lastIdx = (seqQ == SEQ_INJ) ? 4'(INJ_LEN - 1) : 4'(REG_LEN - 1);
  wire isBurst   = (seqQ == SEQ_INJ) ? jBurst : rBurst;
  // in burst mode the injected group converts one channel per trigger
  wire [2:0] burstMax = (seqQ == SEQ_INJ) ? 3'h0 : bcnt;
  wire groupEnd  = slotEnd && (idxQ == lastIdx || !scanOn);
  wire burstEnd  = slotEnd && isBurst && (burstQ == burstMax);

  // watchdog compare on the finishing slot
  wire groupWatched = (seqQ == SEQ_REG) ? ctrlQ[C_WREG] :
                      (seqQ == SEQ_INJ) ? ctrlQ[C_WINJ] : 1'b0;
  wire chanWatched  = !ctrlQ[C_WSINGLE] || (channelOut == watchCh);
  wire outOfRange   = (sampleIn > highQ) || (sampleIn < lowQ);
  wire alarmNow     = slotEnd && groupWatched && chanWatched && outOfRange;
  // an enabled alarm in scan mode stops the sequence
  wire abortScan    = alarmNow && ctrlQ[C_WATCH_IE] && scanOn;

  wire startReg = (seqQ == SEQ_IDLE) && regularTrig && !injectedTrig;
  wire startInj = (seqQ == SEQ_IDLE) && (injectedTrig || autoPendQ);
  wire stopSeq  = groupEnd || burstEnd || abortScan;
  wire regDone  = slotEnd && (seqQ == SEQ_REG) && groupEnd && !abortScan;
  wire injDone  = slotEnd && (seqQ == SEQ_INJ) && groupEnd && !abortScan;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seqQ   <= SEQ_IDLE;
      idxQ   <= 4'h0;
      slotQ  <= 8'h00;
      burstQ <= 3'h0;
    end else begin
      case (seqQ)
        SEQ_IDLE: begin
          burstQ <= 3'h0;
          slotQ  <= 8'(CONV_CYCLES - 1);
          if (startInj) begin
            seqQ <= SEQ_INJ;
            idxQ <= jBurst ? jBaseQ : 4'h0;
          end else if (startReg) begin
            seqQ <= SEQ_REG;
            idxQ <= rBurst ? rBaseQ : 4'h0;
          end
        end
        SEQ_REG, SEQ_INJ: begin
          if (slotEnd) begin
            slotQ <= 8'(CONV_CYCLES - 1);
            if (stopSeq) begin
              seqQ <= SEQ_IDLE;
            end else begin
              idxQ   <= idxQ + 4'h1;
              burstQ <= burstQ + 3'h1;
            end
          end else begin
            slotQ <= slotQ - 8'h01;
          end
        end
        default: seqQ <= SEQ_IDLE;
      endcase
    end
  end

  // burst subgroup bases wrap to zero after the last subgroup
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rBaseQ <= 4'h0;
      jBaseQ <= 4'h0;
    end else if (slotEnd && stopSeq) begin
      if (seqQ == SEQ_REG) rBaseQ <= groupEnd ? 4'h0 : idxQ + 4'h1;
      if (seqQ == SEQ_INJ) jBaseQ <= groupEnd ? 4'h0 : idxQ + 4'h1;
    end
  end

  // automatic injected follow-up after a completed regular group
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      autoPendQ <= 1'b0;
    end else if (regDone && ctrlQ[C_AUTOJ]) begin
      autoPendQ <= 1'b1;
    end else if (startInj) begin
      autoPendQ <= 1'b0;
    end
  end

  // latest result, kept for the regular result register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resultQ <= 12'h000;
    end else if (slotEnd && seqQ == SEQ_REG) begin
      resultQ <= sampleIn;
    end
  end

  // ---------------------------------------------------------------
  // status flags: hardware set wins over software clear
  // ---------------------------------------------------------------
  wire stWr   = wrNow && (paddr == STATUS_OFS);
  wire resRd  = rdNow && (paddr == RESULT_OFS);
  wire [4:0] clr = stWr ? ~pwdata[4:0] : 5'h00;
  logic [4:0] setV;
  always_comb begin
    setV = 5'h00;
    setV[ST_RSTART] = startReg && !startInj;
    setV[ST_JSTART] = startInj;
    setV[ST_JDONE]  = injDone;
    setV[ST_DONE]   = regDone || injDone;
    setV[ST_WATCH]  = alarmNow;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      statusQ <= STATUS_RST[4:0];
    end else begin
      statusQ <= (statusQ & ~clr & ~(resRd ? 5'h02 : 5'h00)) | setV;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqOut     <= 1'b0;
      touchKeyOn <= 1'b0;
      channelOut <= 4'h0;
      convActive <= 1'b0;
    end else begin
      irqOut <= (statusQ[ST_JDONE] & ctrlQ[C_JDONE_IE]) |
                (statusQ[ST_WATCH] & ctrlQ[C_WATCH_IE]) |
                (statusQ[ST_DONE]  & ctrlQ[C_DONE_IE]);
      touchKeyOn <= ctrlQ[C_TOUCH_KEY_UNIT];
      channelOut <= idxQ;
      convActive <= (seqQ != SEQ_IDLE);
    end
  end

endmodule
`default_nettype wire

/* File: asc_ctrl_checker.sv */
/* checker for the converter status/control block: apb timing, touch key,
   trigger start and interrupt release. sees only the top ports; bound from tb_top. */
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_checker
  import asc_pkg::*;
(
  input wire logic        ref_clk,      // clock
  input wire logic        rst,          // sync reset
  input wire logic        psel,         // apb select
  input wire logic        penable,      // apb access
  input wire logic        pwrite,       // apb direction
  input wire logic [11:0] paddr,        // apb address
  input wire logic [31:0] pwdata,       // apb write data
  input wire logic [31:0] prdata,       // apb read data
  input wire logic        pready,       // apb ready
  input wire logic        pslverr,      // apb error
  input wire logic        regularTrig,  // regular trigger
  input wire logic        injectedTrig, // injected trigger
  input wire logic [11:0] sampleIn,     // sample
  input wire logic [3:0]  channelOut,   // channel
  input wire logic        convActive,   // busy
  input wire logic        touchKeyOn,   // touch key enable
  input wire logic        irqOut        // interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic mapped;
  assign mapped = paddr inside {STATUS_OFS, CTRL1_OFS, WHIGH_OFS, WLOW_OFS, RESULT_OFS};
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_slverr_map: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  a_unmapped_zero: assert property (pready && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (pready && !pwrite |-> (paddr != STATUS_OFS ||
    prdata[31:5] == 27'h0) && (paddr != CTRL1_OFS || (prdata & ~CTRL1_MASK) == 32'h0))
    else $error("reserved bits not zero");
  a_touch_key: assert property (pready && pwrite && paddr == CTRL1_OFS |->
    ##2 touchKeyOn == $past(pwdata[C_TOUCH_KEY_UNIT], 2)) else $error("touch key not following");
  a_start_busy: assert property ((regularTrig || injectedTrig) && !convActive |-> ##2 convActive)
    else $error("trigger did not start");
  a_active_hold: assert property ($rose(convActive) |-> convActive [*8])
    else $error("slot too short");
  a_irq_drop: assert property ($fell(irqOut) |-> $past(pready) || $past(pready, 2))
    else $error("interrupt dropped without access");
  cover property ($rose(convActive));
  cover property ($rose(irqOut));
  cover property (pready && pslverr);
endmodule
`default_nettype wire

/* File: tb_top.sv */
/* self-checking bench for asc_ctrl: apb tasks, a read scoreboard queue,
   trigger and watchdog cases. assumes the zero-wait apb slave of the design. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asc_pkg::*;
  logic        ref_clk, rst, psel, penable, pwrite, regularTrig, injectedTrig;
  logic        pready, pslverr, convActive, touchKeyOn, irqOut;
  logic [11:0] paddr, sampleIn;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  channelOut;
  logic [32:0] expQ [$];
  int          n_errors = 0;
  int          total_checks = 0;
  // cases: control word, injected trigger, expected status, expected irq
  // the last case runs a scan that an enabled alarm aborts: no done flag
  // case 6 uses the automatic follow with no injected trigger driven at all
  logic [31:0] caseCtrl [8] = '{32'h00800060, 32'h00400060, 32'h00400080, 32'h00800040,
                                 32'h00800265, 32'h00800260, 32'h00000420, 32'h00800140};
  logic [4:0]  caseSt [8]   = '{5'h13, 5'h12, 5'h0f, 5'h0e, 5'h12, 5'h13, 5'h1e, 5'h11};
  logic [7:0]  caseInj      = 8'b00001100;
  logic [7:0]  caseIrq      = 8'b11110111;
  asc_ctrl asc_ctrl_inst (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .regularTrig, .injectedTrig, .sampleIn, .channelOut, .convActive,
    .touchKeyOn, .irqOut);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t pin %b expected %b", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expQ.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  // a trigger pulse, then wait for the sequencer to go idle
  task automatic conv(input logic inj);
    @(posedge ref_clk);
    {regularTrig, injectedTrig} <= {!inj, inj};
    @(posedge ref_clk);
    {regularTrig, injectedTrig} <= 2'b00;
    repeat (3) @(posedge ref_clk);
    while (convActive === 1'b1) @(posedge ref_clk);
    // an automatic injected follow-up starts after a short idle gap
    repeat (3) @(posedge ref_clk);
    while (convActive === 1'b1) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      if (expQ.size() == 0) begin
        n_errors++;
        $display("BAD t=%0t unexpected read", $time);
      end else begin
        chk_rd({pslverr, prdata}, expQ.pop_front());
      end
    end
  end
  initial begin
    #(8 * 40000);
    n_errors++;
    close_out();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst, psel, penable, pwrite, regularTrig, injectedTrig} = 6'b100000;
    {paddr, sampleIn, pwdata} = '0;
    void'($urandom(32'h3ab5));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(STATUS_OFS, {1'b0, STATUS_RST});
    rd(CTRL1_OFS, {1'b0, CTRL1_RST});
    rd(WHIGH_OFS, {21'h0, WHIGH_RST});
    xfer(1'b1, 12'h008, 32'hffffffff);
    rd(12'h008, {1'b1, 32'h0});
    $display("test reset values done");
    repeat (4) begin
      d = $urandom;
      xfer(1'b1, CTRL1_OFS, d);
      rd(CTRL1_OFS, {1'b0, d & CTRL1_MASK});
      chk_pin(touchKeyOn, d[C_TOUCH_KEY_UNIT]);
    end
    $display("test control words done");
    // limits only keep their low twelve bits
    xfer(1'b1, WHIGH_OFS, 32'hfffff100);
    xfer(1'b1, WLOW_OFS, 32'h00000010);
    rd(WHIGH_OFS, {21'h0, 12'h100});
    for (int k = 0; k < 8; k++) begin
      sampleIn <= 12'h101 + 12'($urandom % 3838);
      xfer(1'b1, CTRL1_OFS, caseCtrl[k]);
      conv(caseInj[k]);
      rd(STATUS_OFS, {28'h0, caseSt[k]});
      chk_pin(irqOut, caseIrq[k]);
      if (k == 0) begin
        rd(RESULT_OFS, {21'h0, sampleIn});
        rd(STATUS_OFS, {28'h0, 5'h11});
        xfer(1'b1, STATUS_OFS, 32'hffffffff);
        rd(STATUS_OFS, {28'h0, 5'h11});
      end
      xfer(1'b1, STATUS_OFS, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk_pin(irqOut, 1'b0);
      $display("test conversion case %0d done", k);
    end
    close_out();
  end
endmodule
bind asc_ctrl asc_ctrl_checker asc_ctrl_checker_inst (.ref_clk(ref_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .regularTrig(regularTrig),
  .injectedTrig(injectedTrig), .sampleIn(sampleIn), .channelOut(channelOut),
  .convActive(convActive), .touchKeyOn(touchKeyOn), .irqOut(irqOut));
`default_nettype wire
